// ==== inc/etd_pkg.sv ====
// What this block does
// - decode insertion code: 00 keep, 01 insert, 10 replace, 11 reserved
// - top control bit picks station address 1 or 0
// - a changed source address forces a recomputed check sequence
// - control field only honoured when the first-segment flag is set
// - low thirteen bits of word 1 give the first buffer byte count
// - zero byte count skips the first buffer
// - word 2 is the first buffer start address
// - word 3 is the next descriptor address
// - low 32 timestamp bits are written back into word 6
// - high 32 timestamp bits are written back into word 7
// - timestamp words valid only with last-segment and stamp-captured flags
package etd_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFF_WORD0 = 8'h00;
  localparam logic [7:0] OFF_WORD1 = 8'h04;
  localparam logic [7:0] OFF_WORD2 = 8'h08;
  localparam logic [7:0] OFF_WORD3 = 8'h0c;
  localparam logic [7:0] OFF_WORD6 = 8'h18;
  localparam logic [7:0] OFF_WORD7 = 8'h1c;
  localparam logic [7:0] OFF_SA0_LO = 8'h20;
  localparam logic [7:0] OFF_SA0_HI = 8'h24;
  localparam logic [7:0] OFF_SA1_LO = 8'h28;
  localparam logic [7:0] OFF_SA1_HI = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------
  // descriptor fields
  // ----------------------------------------
  localparam int FIRST_SEG_BIT = 28;
  localparam int LAST_SEG_BIT = 29;
  localparam int STAMP_FLAG_BIT = 17;
  localparam int SA_SEL_BIT = 31;
  localparam int SA_MODE_LO = 29;
  localparam int BCNT_W = 13;
  localparam logic [1:0] SOURCE_ADDR_INSERT_CTRL_NONE = 2'h0;
  localparam logic [1:0] SOURCE_ADDR_INSERT_CTRL_INS = 2'h1;
  localparam logic [1:0] SOURCE_ADDR_INSERT_CTRL_REP = 2'h2;
  localparam logic [1:0] SOURCE_ADDR_INSERT_CTRL_RSVD = 2'h3;

  // ----------------------------------------
  // frame editing
  // ----------------------------------------
  localparam logic [3:0] SA_FIRST = 4'h6;
  localparam logic [3:0] SA_END = 4'hc;
  localparam logic [2:0] DLY_FULL = 3'h4;
  localparam logic [1:0] TAIL_LAST = 2'h3;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320;

  typedef enum logic [1:0] {SA_KEEP, SA_INSERT, SA_REPLACE} etd_sa_mode_type;
  typedef enum logic {PH_DATA, PH_TAIL} etd_phase_type;

  typedef struct packed {
    etd_sa_mode_type sa_mode;
    logic sa_sel;
    logic [12:0] buf1_count;
    logic buf1_skip;
    logic [31:0] buf1_addr;
    logic [31:0] next_addr;
  } etd_desc_type;

  localparam etd_desc_type DESC_RST = '{sa_mode: SA_KEEP, sa_sel: 1'b0,
    buf1_count: 13'h0000, buf1_skip: 1'b1, buf1_addr: 32'h0, next_addr: 32'h0};

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } etd_beat_type;

endpackage

// ==== hw/etd_crc32.sv ====
`timescale 1ns/100ps
module etd_crc32 (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);

  // reflected ethernet crc, lsb of each byte first
  always_comb begin
    crc_out = crc_in;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[0] ^ data[i]) begin
        crc_out = (crc_out >> 1) ^ etd_pkg::CRC_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end

endmodule // etd_crc32

// ==== hw/etd_desc_decode.sv ====
`timescale 1ns/100ps
module etd_desc_decode (
  input wire logic [31:0] word0,
  input wire logic [31:0] word1,
  input wire logic [31:0] word2,
  input wire logic [31:0] word3,
  output etd_pkg::etd_desc_type desc
);

  always_comb begin
    desc.sa_sel = word1[etd_pkg::SA_SEL_BIT];
    unique case (word1[etd_pkg::SA_MODE_LO +: 2])
      etd_pkg::SOURCE_ADDR_INSERT_CTRL_NONE: desc.sa_mode = etd_pkg::SA_KEEP;
      etd_pkg::SOURCE_ADDR_INSERT_CTRL_INS: desc.sa_mode = etd_pkg::SA_INSERT;
      etd_pkg::SOURCE_ADDR_INSERT_CTRL_REP: desc.sa_mode = etd_pkg::SA_REPLACE;
      etd_pkg::SOURCE_ADDR_INSERT_CTRL_RSVD: desc.sa_mode = etd_pkg::SA_KEEP;
    endcase
    if (!word0[etd_pkg::FIRST_SEG_BIT]) begin
      desc.sa_mode = etd_pkg::SA_KEEP;
    end
    desc.buf1_count = word1[etd_pkg::BCNT_W-1:0];
    desc.buf1_skip = (word1[etd_pkg::BCNT_W-1:0] == 13'h0000);
    desc.buf1_addr = word2;
    desc.next_addr = word3;
  end

endmodule // etd_desc_decode

// ==== hw/etd_tx_desc.sv ====
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module etd_tx_desc (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output etd_pkg::etd_desc_type desc,
  input wire logic stamp_valid,
  input wire logic [63:0] stamp_value,
  input wire logic in_valid,
  input wire etd_pkg::etd_beat_type in_beat,
  output logic in_ready,
  output logic out_valid,
  output etd_pkg::etd_beat_type out_beat,
  input wire logic out_ready
);

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  logic a_wr_ff;
  logic rd_wait_ff;
  logic [7:0] addr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic take;

  // reads cost one wait state so hrdata comes from a flop
  assign hreadyout = !rd_wait_ff;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      a_wr_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      a_wr_ff <= take && hwrite;
      rd_wait_ff <= take && !hwrite;
      if (take) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= etd_pkg::WORD_RST;
    end else if (rd_wait_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------
  // descriptor words
  // ----------------------------------------
  logic [31:0] word0_ff, word1_ff, word2_ff, word3_ff, word6_ff, word7_ff;
  logic [31:0] sa0_lo_ff, sa0_hi_ff, sa1_lo_ff, sa1_hi_ff;
  logic stamp_take;
  etd_pkg::etd_desc_type nxt_desc;

  // stamp only lands in a descriptor that closes a frame
  assign stamp_take = stamp_valid && word0_ff[etd_pkg::LAST_SEG_BIT];

  // set of the captured flag wins over a software rewrite
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      word0_ff <= etd_pkg::WORD_RST;
    end else begin
      if (a_wr_ff && addr_ff == etd_pkg::OFF_WORD0) begin
        word0_ff <= hwdata;
      end
      if (stamp_take) begin
        word0_ff[etd_pkg::STAMP_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      word1_ff <= etd_pkg::WORD_RST;
      word2_ff <= etd_pkg::WORD_RST;
      word3_ff <= etd_pkg::WORD_RST;
    end else if (a_wr_ff) begin
      if (addr_ff == etd_pkg::OFF_WORD1) begin
        word1_ff <= hwdata;
      end
      if (addr_ff == etd_pkg::OFF_WORD2) begin
        word2_ff <= hwdata;
      end
      if (addr_ff == etd_pkg::OFF_WORD3) begin
        word3_ff <= hwdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sa0_lo_ff <= etd_pkg::WORD_RST;
      sa0_hi_ff <= etd_pkg::WORD_RST;
      sa1_lo_ff <= etd_pkg::WORD_RST;
      sa1_hi_ff <= etd_pkg::WORD_RST;
    end else if (a_wr_ff) begin
      if (addr_ff == etd_pkg::OFF_SA0_LO) begin
        sa0_lo_ff <= hwdata;
      end
      if (addr_ff == etd_pkg::OFF_SA0_HI) begin
        sa0_hi_ff <= {16'h0000, hwdata[15:0]};
      end
      if (addr_ff == etd_pkg::OFF_SA1_LO) begin
        sa1_lo_ff <= hwdata;
      end
      if (addr_ff == etd_pkg::OFF_SA1_HI) begin
        sa1_hi_ff <= {16'h0000, hwdata[15:0]};
      end
    end
  end

  // words 6 and 7 are written by hardware only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      word6_ff <= etd_pkg::WORD_RST;
      word7_ff <= etd_pkg::WORD_RST;
    end else if (stamp_take) begin
      word6_ff <= stamp_value[31:0];
      word7_ff <= stamp_value[63:32];
    end
  end

  etd_desc_decode u_decode (
    .word0(word0_ff),
    .word1(word1_ff),
    .word2(word2_ff),
    .word3(word3_ff),
    .desc(nxt_desc)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      desc <= etd_pkg::DESC_RST;
    end else begin
      desc <= nxt_desc;
    end
  end

  // ----------------------------------------
  // frame editor
  // ----------------------------------------
  etd_pkg::etd_phase_type phase_ff;
  etd_pkg::etd_sa_mode_type mode_ff;
  logic [3:0] pos_ff;
  logic [47:0] sa_ff;
  logic [31:0] dly_ff;
  logic [2:0] dcnt_ff;
  logic [1:0] tcnt_ff;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [31:0] fcs;
  logic [47:0] sa_sh;
  logic [3:0] sa_idx;
  logic [7:0] e_data;
  logic [7:0] tail_byte;
  logic adv, sa_win, insert_now, replace_now;
  logic e_valid, e_fire, pop, tail_fire;

  assign adv = !out_valid || out_ready;
  assign sa_win = pos_ff >= etd_pkg::SA_FIRST && pos_ff < etd_pkg::SA_END;
  assign insert_now = phase_ff == etd_pkg::PH_DATA && sa_win && mode_ff == etd_pkg::SA_INSERT;
  assign replace_now = sa_win && mode_ff == etd_pkg::SA_REPLACE;
  assign sa_idx = pos_ff - etd_pkg::SA_FIRST;
  assign sa_sh = sa_ff >> {sa_idx[2:0], 3'h0};
  // insertion stalls the source while the six address bytes go out
  assign in_ready = adv && phase_ff == etd_pkg::PH_DATA && !insert_now;
  assign e_valid = phase_ff == etd_pkg::PH_DATA && (insert_now || in_valid);
  assign e_fire = adv && e_valid;
  assign e_data = (insert_now || replace_now) ? sa_sh[7:0] : in_beat.data;
  assign pop = e_fire && dcnt_ff == etd_pkg::DLY_FULL;
  assign tail_fire = adv && phase_ff == etd_pkg::PH_TAIL;
  assign fcs = ~crc_ff;
  // an edited frame drops its held check bytes for fresh ones
  assign tail_byte = (mode_ff != etd_pkg::SA_KEEP) ? fcs[{tcnt_ff, 3'h0} +: 8] : dly_ff[31:24];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= etd_pkg::SA_KEEP;
      sa_ff <= 48'h0000_0000_0000;
    end else if (e_fire && pos_ff == 4'h0) begin
      mode_ff <= desc.sa_mode;
      sa_ff <= desc.sa_sel ? {sa1_hi_ff[15:0], sa1_lo_ff} : {sa0_hi_ff[15:0], sa0_lo_ff};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= etd_pkg::PH_DATA;
      pos_ff <= 4'h0;
      dcnt_ff <= 3'h0;
      tcnt_ff <= 2'h0;
    end else if (e_fire) begin
      if (pos_ff < etd_pkg::SA_END) begin
        pos_ff <= pos_ff + 4'h1;
      end
      if (dcnt_ff < etd_pkg::DLY_FULL) begin
        dcnt_ff <= dcnt_ff + 3'h1;
      end
      if (in_beat.last && !insert_now) begin
        phase_ff <= etd_pkg::PH_TAIL;
        tcnt_ff <= 2'h0;
      end
    end else if (tail_fire) begin
      tcnt_ff <= tcnt_ff + 2'h1;
      if (tcnt_ff == etd_pkg::TAIL_LAST) begin
        phase_ff <= etd_pkg::PH_DATA;
        pos_ff <= 4'h0;
        dcnt_ff <= 3'h0;
      end
    end
  end

  // four-byte hold keeps the incoming check bytes back until the tail phase
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dly_ff <= 32'h0000_0000;
    end else if (e_fire) begin
      dly_ff <= {dly_ff[23:0], e_data};
    end else if (tail_fire) begin
      dly_ff <= {dly_ff[23:0], 8'h00};
    end
  end

  etd_crc32 u_crc (
    .crc_in(crc_ff),
    .data(dly_ff[31:24]),
    .crc_out(nxt_crc)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      crc_ff <= etd_pkg::CRC_INIT;
    end else if (pop) begin
      crc_ff <= nxt_crc;
    end else if (tail_fire && tcnt_ff == etd_pkg::TAIL_LAST) begin
      crc_ff <= etd_pkg::CRC_INIT;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_beat <= '{data: 8'h00, last: 1'b0};
    end else if (adv) begin
      out_valid <= pop || tail_fire;
      out_beat.data <= tail_fire ? tail_byte : dly_ff[31:24];
      out_beat.last <= tail_fire && tcnt_ff == etd_pkg::TAIL_LAST;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    unique case (addr_ff)
      etd_pkg::OFF_WORD0: rd_mux = word0_ff;
      etd_pkg::OFF_WORD1: rd_mux = word1_ff;
      etd_pkg::OFF_WORD2: rd_mux = word2_ff;
      etd_pkg::OFF_WORD3: rd_mux = word3_ff;
      etd_pkg::OFF_WORD6: rd_mux = word6_ff;
      etd_pkg::OFF_WORD7: rd_mux = word7_ff;
      etd_pkg::OFF_SA0_LO: rd_mux = sa0_lo_ff;
      etd_pkg::OFF_SA0_HI: rd_mux = sa0_hi_ff;
      etd_pkg::OFF_SA1_LO: rd_mux = sa1_lo_ff;
      etd_pkg::OFF_SA1_HI: rd_mux = sa1_hi_ff;
      etd_pkg::OFF_STATUS: rd_mux = {22'h000000, phase_ff, dcnt_ff, 2'h0, pos_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  mode_decode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    desc.sa_mode == etd_pkg::SA_INSERT |-> $past(word0_ff[etd_pkg::FIRST_SEG_BIT]) &&
      $past(word1_ff[etd_pkg::SA_MODE_LO +: 2]) == etd_pkg::SOURCE_ADDR_INSERT_CTRL_INS)
    else $error("insert mode without insert code");
  insert_stall_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    insert_now && adv |-> !in_ready ##1
      dly_ff[7:0] == $past(sa_ff[{pos_ff[2:0] - etd_pkg::SA_FIRST[2:0], 3'h0} +: 8]))
    else $error("address byte not inserted while source held");
  sa_select_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    desc.sa_sel == $past(word1_ff[etd_pkg::SA_SEL_BIT]))
    else $error("station address select wrong");
  fcs_swap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tail_fire && mode_ff != etd_pkg::SA_KEEP |=> out_valid && out_beat.data == $past(fcs[{tcnt_ff, 3'h0} +: 8]))
    else $error("check byte not recomputed");
  first_seg_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !$past(word0_ff[etd_pkg::FIRST_SEG_BIT]) |-> desc.sa_mode == etd_pkg::SA_KEEP)
    else $error("control honoured without first segment");
  byte_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    desc.buf1_count == $past(word1_ff[etd_pkg::BCNT_W-1:0]))
    else $error("buffer byte count wrong");
  zero_skip_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    desc.buf1_skip == ($past(word1_ff[etd_pkg::BCNT_W-1:0]) == 13'h0000))
    else $error("zero size skip wrong");
  buf_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    desc.buf1_addr == $past(word2_ff))
    else $error("buffer address wrong");
  next_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    desc.next_addr == $past(word3_ff))
    else $error("next descriptor address wrong");
  stamp_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stamp_valid && word0_ff[etd_pkg::LAST_SEG_BIT] |=> word6_ff == $past(stamp_value[31:0]))
    else $error("stamp low word not written");
  stamp_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stamp_valid && word0_ff[etd_pkg::LAST_SEG_BIT] |=>
      word7_ff == $past(stamp_value[63:32]) && word0_ff[etd_pkg::STAMP_FLAG_BIT])
    else $error("stamp high word or flag not written");
  stamp_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    stamp_valid && !word0_ff[etd_pkg::LAST_SEG_BIT] |=> $stable(word6_ff) && $stable(word7_ff))
    else $error("stamp written without last segment");
  reserved_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $past(word1_ff[etd_pkg::SA_MODE_LO +: 2]) == etd_pkg::SOURCE_ADDR_INSERT_CTRL_RSVD |-> desc.sa_mode == etd_pkg::SA_KEEP)
    else $error("reserved code edits frame");

endmodule // etd_tx_desc

// ==== sim/etd_frame_src.sv ====
`timescale 1ns/100ps
module etd_frame_src (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic with_sa,
  input wire logic slow,
  input wire logic in_ready,
  output logic in_valid,
  output etd_pkg::etd_beat_type in_beat,
  output logic out_ready
);
  // ----------------------------------------
  // frame source and stalling sink
  // ----------------------------------------
  logic [4:0] idx_ff;
  logic [3:0] tick_ff;
  logic [4:0] len;

  assign len = with_sa ? 5'h16 : 5'h10;

  // da, optional source address, body, then four check bytes
  function automatic logic [7:0] frame_byte(input logic [4:0] k);
    if (k < 5'h6) return 8'h10 + {3'h0, k};
    if (with_sa && k < 5'hc) return 8'h20 + {3'h0, k};
    if (k < len - 5'h4) return 8'h30 + {3'h0, k};
    return 8'hf0 + {3'h0, k};
  endfunction

  // slow sink takes one beat in four, so the hold path gets exercised
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 4'h0;
      out_ready <= 1'b0;
    end else begin
      tick_ff <= tick_ff + 4'h1;
      out_ready <= !slow || tick_ff[1:0] == 2'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      in_valid <= 1'b0;
      idx_ff <= 5'h0;
      in_beat <= '0;
    end else if (!in_valid) begin
      if (start) begin
        in_valid <= 1'b1;
        idx_ff <= 5'h0;
        in_beat <= '{data: frame_byte(5'h0), last: 1'b0};
      end
    end else if (in_ready) begin
      if (in_beat.last) begin
        // released line must not keep the last byte
        in_valid <= 1'b0;
        in_beat <= '{data: ~in_beat.data, last: 1'b0};
      end else begin
        idx_ff <= idx_ff + 5'h1;
        in_beat <= '{data: frame_byte(idx_ff + 5'h1), last: idx_ff + 5'h1 == len - 5'h1};
      end
    end
  end
endmodule // etd_frame_src

// ==== sim/tb.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module tb;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  typedef struct packed {logic fs; logic [1:0] code; logic sel; logic [12:0] bcnt;} etd_row_type;
  localparam logic [47:0] SA0 = 48'h6655_4433_2211;
  localparam logic [47:0] SA1 = 48'heedd_ccbb_aa99;
  etd_row_type rows[6] = '{'{1'b1, 2'h0, 1'b0, 13'h0000}, '{1'b1, 2'h1, 1'b0, 13'h1fff},
    '{1'b1, 2'h2, 1'b1, 13'h0001}, '{1'b1, 2'h3, 1'b1, 13'h0040},
    '{1'b0, 2'h2, 1'b1, 13'h0000}, '{1'b1, 2'h1, 1'b1, 13'h0800}};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, in_valid, in_ready, out_valid, out_ready;
  logic stamp_valid = 1'b0;
  logic [63:0] stamp_value = 64'h0;
  logic start = 1'b0;
  logic with_sa = 1'b1;
  logic slow = 1'b0;
  etd_pkg::etd_desc_type desc;
  etd_pkg::etd_beat_type in_beat, out_beat;
  logic [7:0] oq[$];
  int n_last = 0, last_pos = 0, bad_count = 0, n_checks = 0;

  always #25 ref_clk = ~ref_clk;

  etd_tx_desc i_etd_tx_desc (.ref_clk(ref_clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .desc(desc), .stamp_valid(stamp_valid), .stamp_value(stamp_value), .in_valid(in_valid),
    .in_beat(in_beat), .in_ready(in_ready), .out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready));

  etd_frame_src i_etd_frame_src (.ref_clk(ref_clk), .resetn(resetn), .start(start), .with_sa(with_sa),
    .slow(slow), .in_ready(in_ready), .in_valid(in_valid), .in_beat(in_beat), .out_ready(out_ready));

  always @(posedge ref_clk) begin
    if (resetn && out_valid === 1'b1 && out_ready === 1'b1) begin
      oq.push_back(out_beat.data);
      if (out_beat.last === 1'b1) begin
        n_last++;
        last_pos = oq.size();
      end
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      if (++i > 50) begin
        bad_count++;
        close_out();
      end
      @(posedge ref_clk);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0, r);
  endtask

  task automatic stamp(input logic [63:0] v);
    stamp_value <= v;
    stamp_valid <= 1'b1;
    @(posedge ref_clk);
    stamp_valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  // independent reflected crc, one byte at a time
  function automatic logic [31:0] crc_b(input logic [31:0] c, input logic [7:0] d);
    c = c ^ {24'h0, d};
    repeat (8) c = c[0] ? (c >> 1) ^ etd_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction

  task automatic run_frame(input logic ws, input logic [1:0] eff, input logic [47:0] sa);
    logic [7:0] ex[$];
    logic [31:0] c;
    int i, n;
    n = ws ? 22 : 16;
    oq.delete();
    n_last = 0;
    for (i = 0; i < 6; i++) ex.push_back(8'h10 + i[7:0]);
    for (i = 0; i < 6; i++) begin
      if (eff != 2'h0) ex.push_back(sa[8*i +: 8]);
      else if (ws) ex.push_back(8'h26 + i[7:0]);
    end
    for (i = ws ? 12 : 6; i < n - 4; i++) ex.push_back(8'h30 + i[7:0]);
    c = 32'hffff_ffff;
    foreach (ex[j]) c = crc_b(c, ex[j]);
    for (i = n - 4; i < n; i++) ex.push_back(eff != 2'h0 ? ~c[8*(i-n+4) +: 8] : 8'hf0 + i[7:0]);
    with_sa <= ws;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    i = 0;
    while (n_last == 0) begin
      if (++i > 400) begin
        bad_count++;
        close_out();
      end
      @(posedge ref_clk);
    end
    `CHK(last_pos, ex.size())
    foreach (ex[j]) `CHK(oq[j], ex[j])
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] ptr;
    logic [1:0] eff;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    wr(etd_pkg::OFF_SA0_LO, 32'h4433_2211);
    wr(etd_pkg::OFF_SA0_HI, 32'hdead_6655);
    wr(etd_pkg::OFF_SA1_LO, 32'hccbb_aa99);
    wr(etd_pkg::OFF_SA1_HI, 32'h0000_eedd);
    rd(etd_pkg::OFF_SA0_HI, r);
    `CHK(r, 32'h0000_6655)
    `CHK(hresp, 1'b0)
    foreach (rows[k]) begin
      eff = !rows[k].fs ? 2'h0 : (rows[k].code == 2'h3) ? 2'h0 : rows[k].code;
      ptr = 32'h8765_4300 + k;
      slow <= k[0];
      wr(etd_pkg::OFF_WORD0, {3'h0, rows[k].fs, 28'h0});
      wr(etd_pkg::OFF_WORD1, {rows[k].sel, rows[k].code, 16'hffff, rows[k].bcnt});
      wr(etd_pkg::OFF_WORD2, ptr);
      wr(etd_pkg::OFF_WORD3, ~ptr);
      repeat (2) @(posedge ref_clk);
      `CHK(desc.buf1_count, rows[k].bcnt)
      `CHK(desc.buf1_skip, rows[k].bcnt == 13'h0)
      `CHK(desc.buf1_addr, ptr)
      `CHK(desc.next_addr, ~ptr)
      `CHK(desc.sa_mode, etd_pkg::etd_sa_mode_type'(eff))
      `CHK(desc.sa_sel, rows[k].sel)
      rd(etd_pkg::OFF_WORD2, r);
      `CHK(r, ptr)
      run_frame(eff != 2'h1, eff, rows[k].sel ? SA1 : SA0);
    end
    wr(etd_pkg::OFF_WORD0, 32'h2000_0000);
    stamp(64'h0123_4567_89ab_cdef);
    rd(etd_pkg::OFF_WORD6, r);
    `CHK(r, 32'h89ab_cdef)
    rd(etd_pkg::OFF_WORD7, r);
    `CHK(r, 32'h0123_4567)
    rd(etd_pkg::OFF_WORD0, r);
    `CHK(r, 32'h2002_0000)
    wr(etd_pkg::OFF_WORD0, 32'h0);
    wr(etd_pkg::OFF_WORD6, 32'h0);
    stamp(64'hffff_0000_1111_2222);
    rd(etd_pkg::OFF_WORD6, r);
    `CHK(r, 32'h89ab_cdef)
    rd(etd_pkg::OFF_WORD0, r);
    `CHK(r, 32'h0)
    wr(8'h40, 32'h5a5a_5a5a);
    rd(8'h40, r);
    `CHK(r, 32'h0)
    // mid-run reset must bring every descriptor field home
    resetn <= 1'b0;
    @(posedge ref_clk);
    `CHK(desc, etd_pkg::DESC_RST)
    `CHK(out_valid, 1'b0)
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(etd_pkg::OFF_WORD1, r);
    `CHK(r, etd_pkg::WORD_RST)
    run_frame(1'b1, 2'h0, SA0);
    // editor must be back at frame start once the tail is out
    rd(etd_pkg::OFF_STATUS, r);
    `CHK(r, 32'h0)
    close_out();
  end
endmodule // tb
